//--- design/scs_clock_defs.vh
`ifndef SCS_CLOCK_DEFS_VH
`define SCS_CLOCK_DEFS_VH

// register offsets
`define SCS_ADDR_W 8
`define SCS_OFF_PWR_CTRL 8'h0c
`define SCS_OFF_CLK_CTRL 8'h0e

// clock_control_register fields
`define SCS_CK_DIV_LO 0
`define SCS_CK_DIV_HI 2
`define SCS_CK_RACT_BIT 5
`define SCS_CK_RSEL_BIT 6
// power_control_register fields
`define SCS_PW_HF_OSCILLATOR_DISABLE_BIT 0

// reset values
`define SCS_DIV_RESET 3'h0
`define SCS_HF_OSCILLATOR_DISABLE_RESET 1'h0

// divider encodings
`define SCS_DIV_1 3'h0
`define SCS_DIV_2 3'h1
`define SCS_DIV_4 3'h2
`define SCS_DIV_8 3'h3
`define SCS_DIV_CNT_W 8
`define SCS_LIM_1 8'h00
`define SCS_LIM_2 8'h01
`define SCS_LIM_4 8'h03
`define SCS_LIM_8 8'h07
`define SCS_LIM_256 8'hff

// ring cycles before a switch to ring takes effect
`define SCS_RING_SWITCH_CYC 4'ha
`define SCS_RING_CNT_W 4
// default hf warmup length in hf cycles
`define SCS_HF_WARMUP_DEF 65536
`define SCS_HF_CNT_W 20

`endif

//--- design/scs_edge_sync.v
// two-stage synchroniser plus rising edge detect for a slow clock or level
module scs_edge_sync (
  // clock and reset
  input wire clk,
  input wire rst,
  // async input
  input wire asyncIn,
  // synchronised level and rising edge pulse
  output wire syncLevel,
  output wire risePulse
);
  reg meta_reg;
  reg sync_reg;
  reg prev_reg;

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
      prev_reg <= 1'b0;
    end else begin
      meta_reg <= asyncIn;
      sync_reg <= meta_reg;
      prev_reg <= sync_reg;
    end
  end

  assign syncLevel = sync_reg;
  assign risePulse = sync_reg & ~prev_reg;
endmodule // scs_edge_sync

//--- design/scs_clock_select.v
`include "scs_clock_defs.vh"

// Functional notes
// - one system clock enable, from hf source or ring oscillator
// - divider 000/001/010/011 give hf /1,/2,/4,/8; top bit set gives /256; ring is never divided
// - after power-on reset run from ring until hf warmup completes
// - no hf warmup completion means ring stays selected forever
// - setting ring_select moves clock to ring after 10 ring cycles
// - ring_active_status bit 5 reads 1 while ring supplies clock
// - clearing ring_select keeps ring until hf warmup completes
// - only power-on reset clears ring_select; stop and other resets keep it
// - stop exit with ring selected waits 10 ring cycles before running
// - hf_oscillator_disable bit 0 stops the hf oscillator, reset 0
module scs_clock_select #(
  parameter HF_WARMUP_CYC = `SCS_HF_WARMUP_DEF
) (
  // clock and resets
  input wire clk,
  input wire rst,
  input wire sysRst,
  // register port
  input wire [`SCS_ADDR_W-1:0] regAddr,
  input wire [15:0] regWrData,
  input wire regWrStb,
  input wire regRdStb,
  output reg [15:0] regRdData,
  // oscillator pins and status
  input wire hfOscClk,
  input wire ringOscClk,
  input wire stopMode,
  // oscillator control
  output reg hfOscDisable,
  // system clock enable and execution gate
  output reg sysClkEn,
  output reg runEnable,
  output reg ringActiveStatus
);
  localparam ST_RING_WAIT = 2'h0;
  localparam ST_RING = 2'h1;
  localparam ST_HF = 2'h2;
  localparam ST_STOP = 2'h3;
  // last count value of the warmup, cut to the counter width on purpose
  localparam [`SCS_HF_CNT_W-1:0] WARM_LAST = HF_WARMUP_CYC - 1;

  reg [1:0] state_reg, state_next;
  reg ringSelect_reg;
  reg [2:0] divSel_reg;
  reg [`SCS_RING_CNT_W-1:0] ringCnt_reg, ringCnt_next;
  reg [`SCS_HF_CNT_W-1:0] hfCnt_reg;
  reg hfWarm_reg;
  reg [`SCS_DIV_CNT_W-1:0] divCnt_reg;
  reg hfPending_reg;
  reg ringPending_reg;
  wire hfSync, hfRise, ringSync, ringRise, stopSync, stopRise;
  wire [`SCS_DIV_CNT_W-1:0] divLimit;
  wire wrClk = regWrStb && regAddr == `SCS_OFF_CLK_CTRL;
  wire wrPwr = regWrStb && regAddr == `SCS_OFF_PWR_CTRL;

  function [`SCS_DIV_CNT_W-1:0] div_limit;
    input [2:0] sel;
    begin
      if (sel[2]) begin
        div_limit = `SCS_LIM_256;
      end else begin
        case (sel)
          `SCS_DIV_1: div_limit = `SCS_LIM_1;
          `SCS_DIV_2: div_limit = `SCS_LIM_2;
          `SCS_DIV_4: div_limit = `SCS_LIM_4;
          `SCS_DIV_8: div_limit = `SCS_LIM_8;
          default: div_limit = `SCS_LIM_1;
        endcase
      end
    end
  endfunction

  assign divLimit = div_limit(divSel_reg);

  scs_edge_sync uHfSync (
    .clk(clk),
    .rst(rst),
    .asyncIn(hfOscClk),
    .syncLevel(hfSync),
    .risePulse(hfRise)
  );

  scs_edge_sync uRingSync (
    .clk(clk),
    .rst(rst),
    .asyncIn(ringOscClk),
    .syncLevel(ringSync),
    .risePulse(ringRise)
  );

  scs_edge_sync uStopSync (
    .clk(clk),
    .rst(rst),
    .asyncIn(stopMode),
    .syncLevel(stopSync),
    .risePulse(stopRise)
  );

  // registers; rst is power-on reset, sysRst leaves ring_select alone
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      ringSelect_reg <= 1'b0;
      divSel_reg <= `SCS_DIV_RESET;
      hfOscDisable <= `SCS_HF_OSCILLATOR_DISABLE_RESET;
    end else if (sysRst) begin
      divSel_reg <= `SCS_DIV_RESET;
      hfOscDisable <= `SCS_HF_OSCILLATOR_DISABLE_RESET;
    end else begin
      if (wrClk) begin
        ringSelect_reg <= regWrData[`SCS_CK_RSEL_BIT];
        divSel_reg <= regWrData[`SCS_CK_DIV_HI:`SCS_CK_DIV_LO];
      end
      // software must only set this with ring selected and active
      if (wrPwr) begin
        hfOscDisable <= regWrData[`SCS_PW_HF_OSCILLATOR_DISABLE_BIT];
      end
    end
  end

  // hf warmup counter; restarts while the oscillator is off or in stop
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      hfCnt_reg <= {`SCS_HF_CNT_W{1'b0}};
      hfWarm_reg <= 1'b0;
    end else if (hfOscDisable || stopSync) begin
      hfCnt_reg <= {`SCS_HF_CNT_W{1'b0}};
      hfWarm_reg <= 1'b0;
    end else if (hfRise && !hfWarm_reg) begin
      // no crystal means no edges, so warmup never ends
      if (hfCnt_reg == WARM_LAST) begin
        hfWarm_reg <= 1'b1;
      end
      hfCnt_reg <= hfCnt_reg + 1'b1;
    end
  end

  // source state machine
  always @* begin
    state_next = state_reg;
    ringCnt_next = ringCnt_reg;
    case (state_reg)
      ST_RING_WAIT: begin
        if (ringRise) begin
          if (ringCnt_reg == `SCS_RING_SWITCH_CYC - 1'b1) begin
            state_next = ST_RING;
            ringCnt_next = {`SCS_RING_CNT_W{1'b0}};
          end else begin
            ringCnt_next = ringCnt_reg + 1'b1;
          end
        end
      end
      ST_RING: begin
        if (stopSync) begin
          state_next = ST_STOP;
        end else if (!ringSelect_reg && hfWarm_reg) begin
          state_next = ST_HF;
        end
      end
      ST_HF: begin
        if (stopSync) begin
          state_next = ST_STOP;
        end else if (ringSelect_reg && ringRise) begin
          if (ringCnt_reg == `SCS_RING_SWITCH_CYC - 1'b1) begin
            state_next = ST_RING;
            ringCnt_next = {`SCS_RING_CNT_W{1'b0}};
          end else begin
            ringCnt_next = ringCnt_reg + 1'b1;
          end
        end else if (!ringSelect_reg) begin
          ringCnt_next = {`SCS_RING_CNT_W{1'b0}};
        end
      end
      ST_STOP: begin
        if (!stopSync) begin
          ringCnt_next = {`SCS_RING_CNT_W{1'b0}};
          // ring selection survives stop; hf path needs a fresh warmup
          state_next = ST_RING_WAIT;
        end
      end
      default: begin
        state_next = ST_RING_WAIT;
      end
    endcase
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg <= ST_RING_WAIT;
      ringCnt_reg <= {`SCS_RING_CNT_W{1'b0}};
    end else begin
      state_reg <= state_next;
      ringCnt_reg <= ringCnt_next;
    end
  end

  // clock enable; a change of source waits for a fresh edge of the new
  // source and drops the half-finished divided pulse of the old one
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      divCnt_reg <= {`SCS_DIV_CNT_W{1'b0}};
      sysClkEn <= 1'b0;
      runEnable <= 1'b0;
      ringActiveStatus <= 1'b1;
      hfPending_reg <= 1'b0;
      ringPending_reg <= 1'b0;
    end else begin
      ringActiveStatus <= (state_next != ST_HF);
      runEnable <= (state_next == ST_RING || state_next == ST_HF);
      sysClkEn <= 1'b0;
      if (state_next == ST_HF) begin
        ringPending_reg <= 1'b0;
        if (state_reg != ST_HF) begin
          hfPending_reg <= 1'b1;
          divCnt_reg <= {`SCS_DIV_CNT_W{1'b0}};
        end else if (hfRise) begin
          hfPending_reg <= 1'b0;
          if (hfPending_reg || divCnt_reg >= divLimit) begin
            divCnt_reg <= {`SCS_DIV_CNT_W{1'b0}};
            sysClkEn <= !hfPending_reg || divLimit == `SCS_LIM_1;
          end else begin
            divCnt_reg <= divCnt_reg + 1'b1;
          end
        end
      end else if (state_next == ST_RING) begin
        divCnt_reg <= {`SCS_DIV_CNT_W{1'b0}};
        hfPending_reg <= 1'b0;
        if (state_reg != ST_RING) begin
          ringPending_reg <= 1'b1;
        end else if (ringRise) begin
          ringPending_reg <= 1'b0;
          sysClkEn <= !ringPending_reg;
        end
      end else begin
        divCnt_reg <= {`SCS_DIV_CNT_W{1'b0}};
        hfPending_reg <= 1'b0;
        ringPending_reg <= 1'b0;
      end
    end
  end

  // read data, valid the cycle after the strobe
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      regRdData <= 16'h0000;
    end else begin
      regRdData <= 16'h0000;
      if (regRdStb) begin
        if (regAddr == `SCS_OFF_CLK_CTRL) begin
          regRdData[`SCS_CK_DIV_HI:`SCS_CK_DIV_LO] <= divSel_reg;
          regRdData[`SCS_CK_RACT_BIT] <= ringActiveStatus;
          regRdData[`SCS_CK_RSEL_BIT] <= ringSelect_reg;
        end else if (regAddr == `SCS_OFF_PWR_CTRL) begin
          regRdData[`SCS_PW_HF_OSCILLATOR_DISABLE_BIT] <= hfOscDisable;
        end
      end
    end
  end

  wire unusedSync = hfSync ^ ringSync ^ stopRise;
endmodule // scs_clock_select

//--- tb/scs_clock_select_assertions.sv
module scs_clock_select_assertions (
  input wire clk,
  input wire rst,
  input wire [7:0] regAddr,
  input wire regRdStb,
  input wire [15:0] regRdData,
  input wire stopMode,
  input wire hfOscDisable,
  input wire sysClkEn,
  input wire runEnable,
  input wire ringActiveStatus
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  rst_state_a: assert property (disable iff (1'b0) rst |-> ringActiveStatus && !runEnable
    && !hfOscDisable && !sysClkEn) else $error("bad state in reset");
  por_wait_a: assert property ($fell(rst) |-> !runEnable [*8])
    else $error("ran before ring warmup");
  rd_idle_a: assert property (!$past(regRdStb) |-> regRdData == 16'h0000)
    else $error("read data not zero");
  hf_oscillator_disable_rd_a: assert property ($past(regRdStb) && $past(regAddr) == 8'h0c
    |-> regRdData == {15'h0000, $past(hfOscDisable)}) else $error("power control read");
  ract_rd_a: assert property ($past(regRdStb) && $past(regAddr) == 8'h0e
    |-> regRdData[5] == $past(ringActiveStatus)) else $error("status bit read");
  hf_oscillator_disable_ring_a: assert property (hfOscDisable |-> ringActiveStatus)
    else $error("hf used while disabled");
  // a handover to hf may tick soon after the last ring tick, so only ring ticks count
  ring_tick_a: assert property (ringActiveStatus && sysClkEn |=>
    (!sysClkEn || !ringActiveStatus) [*4])
    else $error("ring tick too fast");
  stop_halt_a: assert property (stopMode [*4] |-> !runEnable)
    else $error("running in stop");
endmodule // scs_clock_select_assertions

bind scs_clock_select scs_clock_select_assertions i_scs_clock_select_assertions (
  .clk(clk), .rst(rst), .regAddr(regAddr), .regRdStb(regRdStb), .regRdData(regRdData),
  .stopMode(stopMode), .hfOscDisable(hfOscDisable), .sysClkEn(sysClkEn),
  .runEnable(runEnable), .ringActiveStatus(ringActiveStatus));

//--- tb/scs_osc_model.sv
module scs_osc_model (
  // control
  input wire logic hfOscDisable,
  input wire logic hfPresent,
  // clocks
  output logic hfOscClk,
  output logic ringOscClk
);
  timeunit 1ns;
  timeprecision 100ps;
  // ring runs free at 1 mhz
  initial begin
    ringOscClk = 1'b0;
    forever #500 ringOscClk = ~ringOscClk;
  end
  // hf at 10 mhz, off-phase to clk; dead without crystal or when disabled
  initial begin
    hfOscClk = 1'b0;
    #7;
    forever #50 hfOscClk = hfPresent && !hfOscDisable && !hfOscClk;
  end
endmodule // scs_osc_model

//--- tb/tb_top.sv
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0;
  logic rst = 1'b0;
  logic sysRst = 1'b0;
  logic regWrStb = 1'b0;
  logic regRdStb = 1'b0;
  logic stopMode = 1'b0;
  logic hfPresent = 1'b0;
  logic [7:0] regAddr = 8'h00;
  logic [15:0] regWrData = 16'h0000;
  wire [15:0] regRdData;
  wire hfOscClk, ringOscClk, hfOscDisable, sysClkEn, runEnable, ringActiveStatus;
  int num_errors = 0;
  int num_checks = 0;
  int n;
  scs_clock_select #(.HF_WARMUP_CYC(8)) i_scs_clock_select (.clk(clk), .rst(rst),
    .sysRst(sysRst), .regAddr(regAddr), .regWrData(regWrData), .regWrStb(regWrStb),
    .regRdStb(regRdStb), .regRdData(regRdData), .hfOscClk(hfOscClk),
    .ringOscClk(ringOscClk), .stopMode(stopMode), .hfOscDisable(hfOscDisable),
    .sysClkEn(sysClkEn), .runEnable(runEnable), .ringActiveStatus(ringActiveStatus));
  scs_osc_model i_scs_osc_model (.hfOscDisable(hfOscDisable), .hfPresent(hfPresent),
    .hfOscClk(hfOscClk), .ringOscClk(ringOscClk));
  initial begin
    forever #10 clk = ~clk;
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic rng(input int v, input int lo, input int hi);
    chk({15'h0000, v >= lo && v <= hi}, 16'h0001);
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    regAddr <= a;
    regWrData <= d;
    regWrStb <= 1'b1;
    @(posedge clk);
    regWrStb <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] exp);
    regAddr <= a;
    regRdStb <= 1'b1;
    @(posedge clk);
    regRdStb <= 1'b0;
    @(negedge clk);
    chk(regRdData, exp);
    @(posedge clk);
  endtask
  // sampled on falling edges so flags have settled
  task automatic waitFor(input bit useRun, input logic v, output int c);
    c = 0;
    do begin
      @(negedge clk);
      c++;
    end while ((useRun ? runEnable : ringActiveStatus) !== v && c < 3000);
    @(posedge clk);
  endtask
  task automatic t_por;
    waitFor(1'b1, 1'b1, n);
    rng(n, 440, 600);
    repeat (1000) @(posedge clk);
    rd(8'h0e, 16'h0020);
    rd(8'h0c, 16'h0000);
    rd(8'h10, 16'h0000);
    hfPresent <= 1'b1;
    waitFor(1'b0, 1'b0, n);
    rng(n, 30, 2999);
    $display("por test done");
  endtask
  task automatic t_div;
    logic [2:0] d;
    for (int k = 0; k < 6; k++) begin
      d = (k < 5) ? 3'(k) : 3'h7;
      wr(8'h0e, {13'h0000, d});
      // first gap may still carry the old ratio
      repeat (3) begin
        n = 0;
        do begin
          @(negedge clk);
          n++;
        end while (sysClkEn !== 1'b1 && n < 3000);
      end
      @(posedge clk);
      rng(n, (d[2] ? 256 : 1 << d[1:0]) * 5, (d[2] ? 256 : 1 << d[1:0]) * 5);
    end
    $display("divider test done");
  endtask
  task automatic t_ring;
    wr(8'h0e, 16'h0047);
    waitFor(1'b0, 1'b1, n);
    rng(n, 440, 600);
    rd(8'h0e, 16'h0067);
    wr(8'h0c, 16'h0001);
    rd(8'h0c, 16'h0001);
    wr(8'h0e, 16'h0000);
    repeat (1000) @(posedge clk);
    rd(8'h0e, 16'h0020);
    wr(8'h0c, 16'h0000);
    waitFor(1'b0, 1'b0, n);
    rng(n, 30, 2999);
    $display("ring test done");
  endtask
  task automatic t_stop;
    wr(8'h0e, 16'h0040);
    waitFor(1'b0, 1'b1, n);
    stopMode <= 1'b1;
    waitFor(1'b1, 1'b0, n);
    rng(n, 1, 10);
    stopMode <= 1'b0;
    waitFor(1'b1, 1'b1, n);
    rng(n, 440, 700);
    rd(8'h0e, 16'h0060);
    sysRst <= 1'b1;
    @(posedge clk);
    sysRst <= 1'b0;
    rd(8'h0e, 16'h0060);
    $display("stop test done");
  endtask
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    // a real edge on rst so the async reset takes hold at time zero
    rst = 1'b1;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    t_por;
    t_div;
    t_ring;
    t_stop;
    tally_and_finish;
  end
  // run needs well under 30000 cycles
  initial begin
    #1ms;
    num_errors++;
    tally_and_finish;
  end
endmodule // tb_top
